// ### hw/aptc_top.sv
// Trigger and request control for converter pairs two to five
//
// Functional notes
// - Each pair has a five-bit trigger selector; code zero disables it.
// - Code 1 uses the pair's software trigger; code 2 the global trigger.
// - Code 3 starts the pair on the special event trigger.
// - Codes 4 to 7 select primary triggers of generators one to four.
// - Code 12 starts on timer one period match; code 31 on timer two.
// - Codes 14 to 17 select secondary triggers of generators one to four.
// - Codes 23 to 26 select current-limit triggers of generators one to four.
// - Pending flag sets when the selected source asserts.
// - Pending flag clears once both channels of the pair converted.
// - With interrupt enable set, completion raises an interrupt request.
// - Software trigger bit requests conversion only under software selection.
// - Software trigger bit clears when the pair's pending flag sets.
// - Pending conversion waits while converter busy, then runs.
// - Control one: high byte pair three, low byte pair two.
// - Control two high byte: enable, pending, trigger, selector of pair five.
// - Control two low byte: same controls for pair four.
`timescale 1ns/10ps
`default_nettype none
module aptc_top
    import aptc_pkg::*;
(
    input  wire logic                  I_CLK_SYS,
    input  wire logic                  I_ARST_N,
    input  wire logic                  I_HSEL,
    input  wire logic [31:0]           I_HADDR,
    input  wire logic [1:0]            I_HTRANS,
    input  wire logic                  I_HWRITE,
    input  wire logic [2:0]            I_HSIZE,
    input  wire logic [31:0]           I_HWDATA,
    input  wire logic                  I_HREADY,
    output logic      [31:0]           O_HRDATA,
    output logic                       O_HREADYOUT,
    output logic                       O_HRESP,
    input  wire logic                  I_SPECIAL_TRIG,
    input  wire logic [3:0]            I_PWM_PRI_TRIG,
    input  wire logic [3:0]            I_PWM_SEC_TRIG,
    input  wire logic [3:0]            I_PWM_CL_TRIG,
    input  wire logic                  I_TMR1_MATCH,
    input  wire logic                  I_TMR2_MATCH,
    input  wire logic                  I_GLOBAL_SW_TRIG,
    output logic                       O_CONV_REQ,
    output logic      [1:0]            O_CONV_PAIR,
    input  wire logic                  I_CONV_ACK,
    input  wire logic                  I_CONV_DONE,
    output logic      [NUM_PAIRS-1:0]  O_PAIR_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Map a selector to a source bit; reserved and off give no source
    function automatic logic src_hit(input logic [4:0] sel, input logic [NUM_SRC-1:0] edges);
        logic hit;
        hit = 1'b0;
        if (sel == SEL_SW_GLOBAL)
            hit = edges[SRC_GLOBAL];
        else if (sel == SEL_SPECIAL)
            hit = edges[SRC_SPECIAL];
        else if (sel >= SEL_PRI_FIRST && sel <= SEL_PRI_LAST)
            hit = edges[SRC_PRI + int'(sel - SEL_PRI_FIRST)];
        else if (sel == SEL_TMR1)
            hit = edges[SRC_TMR1];
        else if (sel == SEL_TMR2)
            hit = edges[SRC_TMR2];
        else if (sel >= SEL_SEC_FIRST && sel <= SEL_SEC_LAST)
            hit = edges[SRC_SEC + int'(sel - SEL_SEC_FIRST)];
        else if (sel >= SEL_CL_FIRST && sel <= SEL_CL_LAST)
            hit = edges[SRC_CL + int'(sel - SEL_CL_FIRST)];
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address phase qualifier shared by the read and write paths
    function automatic logic bus_take(
        input logic       sel,
        input logic       ready,
        input logic [1:0] trans
    );
        logic take;
        take = sel && ready && (trans == HTRANS_NONSEQ);
        return take;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Writable control registers
    function automatic logic reg_is_ctrl(input logic [31:0] addr);
        logic ok;
        ok = 1'b0;
        if (addr == ADDR_CTRL_ONE)
            ok = 1'b1;
        else if (addr == ADDR_CTRL_TWO)
            ok = 1'b1;
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pairs two and three sit in control one, four and five in control two
    function automatic logic pair_in_reg(input int pair, input logic [31:0] addr);
        logic in_reg;
        in_reg = (addr == ADDR_CTRL_ONE) == (pair < 2);
        return in_reg;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bit position of a field inside the byte lane that serves a pair
    function automatic int lane_pos(input int pair, input int fld);
        int pos;
        pos = (pair % 2) * BYTE_W + fld;
        return pos;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read word of one register; unmapped offsets read as zero
    function automatic logic [31:0] read_word(
        input logic [31:0]       addr,
        input logic [BYTE_W-1:0] img0,
        input logic [BYTE_W-1:0] img1,
        input logic [BYTE_W-1:0] img2,
        input logic [BYTE_W-1:0] img3,
        input logic [3:0]        status
    );
        logic [31:0] word;
        word = '0;
        if (addr == ADDR_CTRL_ONE)
            word = {16'h0000, img1, img0};
        else if (addr == ADDR_CTRL_TWO)
            word = {16'h0000, img3, img2};
        else if (addr == ADDR_STATUS)
            word = {28'h0000000, status};
        return word;
    endfunction

    typedef struct packed {
        logic [NUM_SRC-1:0]    sync1;
        logic [NUM_SRC-1:0]    sync2;
        logic [NUM_SRC-1:0]    last;
        logic [NUM_PAIRS-1:0]  irq_en;
        logic [NUM_PAIRS-1:0]  pend;
        logic [NUM_PAIRS-1:0]  sw_trig;
        logic [NUM_PAIRS-1:0][SEL_W-1:0] sel;
        logic [NUM_PAIRS-1:0]  irq;
        aptc_seq_e             seq;
        logic [1:0]            pair;
        logic                  wr_pend;
        logic                  rd_pend;
        logic [31:0]           addr;
        logic [31:0]           rdata;
    } aptc_state_s;

    aptc_state_s st_reg;
    aptc_state_s st_next;
    logic [NUM_SRC-1:0] src_raw;
    logic [NUM_SRC-1:0] src_edge;
    logic               addr_ok;
    logic [15:0]        wr_half;
    logic [1:0]         lowest;
    logic               any_pend;
    logic [BYTE_W-1:0]  byte_img [NUM_PAIRS];
    logic [3:0]         status_now;

    assign src_raw = {I_GLOBAL_SW_TRIG, I_TMR2_MATCH, I_TMR1_MATCH, I_PWM_CL_TRIG,
                      I_PWM_SEC_TRIG, I_PWM_PRI_TRIG, I_SPECIAL_TRIG};
    assign src_edge = st_reg.sync2 & ~st_reg.last;

    ////////////////////////////////////////////////////////////////////////
    // Per-pair byte image as software sees it
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAIRS; gp++)
        begin : g_img
            always_comb
            begin
                byte_img[gp] = {st_reg.irq_en[gp], st_reg.pend[gp], st_reg.sw_trig[gp], st_reg.sel[gp]};
            end
        end
    endgenerate

    // Status bits: busy, served pair, any pending
    always_comb
    begin
        status_now = {st_reg.seq != APTC_IDLE, st_reg.pair, any_pend};
    end

    always_comb
    begin
        lowest = 2'd0;
        any_pend = 1'b0;
        for (int k = NUM_PAIRS - 1; k >= 0; k--)
        begin
            if (st_reg.pend[k])
            begin
                lowest = 2'(k);
                any_pend = 1'b1;
            end
        end
    end

    always_comb
    begin
        logic hit;
        logic wr_now;
        logic rd_now;
        hit = 1'b0;
        wr_now = 1'b0;
        rd_now = 1'b0;
        st_next = st_reg;
        st_next.sync1 = src_raw;
        st_next.sync2 = st_reg.sync1;
        st_next.last  = st_reg.sync2;
        st_next.irq   = '0;
        addr_ok = reg_is_ctrl(st_reg.addr);
        wr_half = I_HWDATA[15:0];
        wr_now = st_reg.wr_pend && addr_ok;
        rd_now = bus_take(I_HSEL, I_HREADY, I_HTRANS) && !I_HWRITE;

        // Bus write lands in data phase; pending bits stay hardware owned
        if (wr_now)
        begin
            for (int p = 0; p < NUM_PAIRS; p++)
            begin
                if (pair_in_reg(p, st_reg.addr))
                begin
                    st_next.irq_en[p] = wr_half[lane_pos(p, FLD_IRQ_EN)];
                    st_next.sw_trig[p] = wr_half[lane_pos(p, FLD_SW_TRIG)];
                    st_next.sel[p] = wr_half[lane_pos(p, FLD_SEL_LO) +: SEL_W];
                end
            end
        end

        // Trigger detection per pair
        for (int p = 0; p < NUM_PAIRS; p++)
        begin
            hit = src_hit(st_reg.sel[p], src_edge);
            if (st_reg.sel[p] == SEL_SW_OWN)
                hit = st_reg.sw_trig[p];
            if (hit && !st_reg.pend[p])
            begin
                st_next.pend[p] = 1'b1;
                st_next.sw_trig[p] = 1'b0;
            end
            else if (st_reg.sel[p] != SEL_SW_OWN && st_reg.sw_trig[p])
                st_next.sw_trig[p] = 1'b0;
        end

        // Sequencer hand-off; waits on acknowledge while converter busy
        case (st_reg.seq)
            APTC_IDLE:
            begin
                if (any_pend)
                begin
                    st_next.pair = lowest;
                    st_next.seq = APTC_REQ;
                end
            end
            APTC_REQ:
            begin
                if (I_CONV_ACK)
                    st_next.seq = APTC_WAIT;
            end
            APTC_WAIT:
            begin
                if (I_CONV_DONE)
                begin
                    st_next.pend[st_reg.pair] = 1'b0;
                    st_next.irq[st_reg.pair] = st_reg.irq_en[st_reg.pair];
                    st_next.seq = APTC_IDLE;
                end
            end
            default:
                st_next.seq = APTC_IDLE;
        endcase

        // Address phase capture and read data
        st_next.wr_pend = bus_take(I_HSEL, I_HREADY, I_HTRANS) && I_HWRITE;
        if (bus_take(I_HSEL, I_HREADY, I_HTRANS))
            st_next.addr = I_HADDR;
        if (rd_now)
        begin
            st_next.rdata = read_word(I_HADDR, byte_img[0], byte_img[1], byte_img[2], byte_img[3],
                                      status_now);
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            st_reg <= '{seq: APTC_IDLE, pair: 2'd0, default: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs; the bus answers at once with OKAY
    assign O_HRDATA    = st_reg.rdata;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;
    assign O_CONV_REQ  = st_reg.seq == APTC_REQ;
    assign O_CONV_PAIR = st_reg.pair;
    assign O_PAIR_IRQ  = st_reg.irq;

endmodule : aptc_top
`default_nettype wire

// ### hw/aptc_pkg.sv
// Package of constants and types for the pair trigger control block
package aptc_pkg;
    localparam int           NUM_PAIRS      = 4;
    localparam int           SEL_W          = 5;
    localparam int           NUM_SRC        = 16;
    // Register byte addresses
    localparam logic [31:0]  ADDR_CTRL_ONE  = 32'h0000_0000;
    localparam logic [31:0]  ADDR_CTRL_TWO  = 32'h0000_0004;
    localparam logic [31:0]  ADDR_STATUS    = 32'h0000_0008;
    localparam logic [15:0]  CTRL_RESET     = 16'h0000;
    // Field positions inside one control byte
    localparam int           FLD_IRQ_EN     = 7;
    localparam int           FLD_PEND       = 6;
    localparam int           FLD_SW_TRIG    = 5;
    localparam int           FLD_SEL_LO     = 0;
    localparam int           BYTE_W         = 8;
    // Selector codes
    localparam logic [4:0]   SEL_OFF        = 5'h00;
    localparam logic [4:0]   SEL_SW_OWN     = 5'h01;
    localparam logic [4:0]   SEL_SW_GLOBAL  = 5'h02;
    localparam logic [4:0]   SEL_SPECIAL    = 5'h03;
    localparam logic [4:0]   SEL_PRI_FIRST  = 5'h04;
    localparam logic [4:0]   SEL_PRI_LAST   = 5'h07;
    localparam logic [4:0]   SEL_TMR1       = 5'h0c;
    localparam logic [4:0]   SEL_SEC_FIRST  = 5'h0e;
    localparam logic [4:0]   SEL_SEC_LAST   = 5'h11;
    localparam logic [4:0]   SEL_CL_FIRST   = 5'h17;
    localparam logic [4:0]   SEL_CL_LAST    = 5'h1a;
    localparam logic [4:0]   SEL_TMR2       = 5'h1f;
    // Hardware source vector bit positions
    localparam int           SRC_SPECIAL    = 0;
    localparam int           SRC_PRI        = 1;
    localparam int           SRC_SEC        = 5;
    localparam int           SRC_CL         = 9;
    localparam int           SRC_TMR1       = 13;
    localparam int           SRC_TMR2       = 14;
    localparam int           SRC_GLOBAL     = 15;
    localparam logic [1:0]   HTRANS_NONSEQ  = 2'b10;

    typedef enum logic [1:0] {
        APTC_IDLE = 2'b00,
        APTC_REQ  = 2'b01,
        APTC_WAIT = 2'b11
    } aptc_seq_e;
endpackage : aptc_pkg

// ### tb/aptc_asserts.sv
// Port checker of the pair trigger block
`timescale 1ns/10ps
`default_nettype none
module aptc_asserts
    import aptc_pkg::*;
(
    input wire logic                 I_CLK_SYS,
    input wire logic                 I_ARST_N,
    input wire logic                 O_HREADYOUT,
    input wire logic                 O_HRESP,
    input wire logic                 O_CONV_REQ,
    input wire logic [1:0]           O_CONV_PAIR,
    input wire logic                 I_CONV_ACK,
    input wire logic                 I_CONV_DONE,
    input wire logic [NUM_PAIRS-1:0] O_PAIR_IRQ
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);
    property p_hold_req; O_CONV_REQ && !I_CONV_ACK |=> O_CONV_REQ; endproperty
    a_hold_req: assert property (p_hold_req) else $error("request dropped before ack");
    property p_hold_pair; O_CONV_REQ && !I_CONV_ACK |=> $stable(O_CONV_PAIR); endproperty
    a_hold_pair: assert property (p_hold_pair) else $error("pair changed while waiting");
    property p_drop_req; O_CONV_REQ && I_CONV_ACK |=> !O_CONV_REQ; endproperty
    a_drop_req: assert property (p_drop_req) else $error("request kept after ack");
    property p_irq_cause; |O_PAIR_IRQ |-> $past(I_CONV_DONE); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without completion");
    property p_irq_pulse; |O_PAIR_IRQ |=> O_PAIR_IRQ == 4'h0; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    property p_irq_one; $onehot0(O_PAIR_IRQ); endproperty
    a_irq_one: assert property (p_irq_one) else $error("several irqs at once");
    property p_ready; O_HREADYOUT; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    property p_resp; !O_HRESP; endproperty
    a_resp: assert property (p_resp) else $error("response not okay");
endmodule // aptc_asserts
bind aptc_top aptc_asserts i_chk (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .O_CONV_REQ(O_CONV_REQ), .O_CONV_PAIR(O_CONV_PAIR), .I_CONV_ACK(I_CONV_ACK),
    .I_CONV_DONE(I_CONV_DONE), .O_PAIR_IRQ(O_PAIR_IRQ));
`default_nettype wire

// ### tb/aptc_seq_model.sv
// Behavioural converter sequencer
`timescale 1ns/10ps
`default_nettype none
module aptc_seq_model
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_req,
    input  wire logic [3:0] i_delay,
    output logic            o_ack,
    output logic            o_done
);
    logic [3:0] cnt_reg;
    logic       busy_reg;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            {cnt_reg, busy_reg, o_ack, o_done} <= '0;
        else
        begin
            {cnt_reg, o_ack, o_done} <= '0;
            // Busy for i_delay cycles before ack and again before done
            if (busy_reg)
                if (cnt_reg == i_delay)
                    {o_done, busy_reg} <= 2'b10;
                else
                    cnt_reg <= cnt_reg + 4'h1;
            else if (i_req && !o_ack)
                if (cnt_reg == i_delay)
                    {o_ack, busy_reg} <= 2'b11;
                else
                    cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule // aptc_seq_model
`default_nettype wire

// ### tb/aptc_top_tb.sv
// Self-checking bench of the pair trigger block
`timescale 1ns/10ps
`default_nettype none
module aptc_top_tb;
    import aptc_pkg::*;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, ack, done, req, hready, hresp;
    logic [1:0]  htrans = 0, pair;
    logic [31:0] haddr = 0, hwdata = 0, rdata, rd;
    logic [15:0] src = 0;
    logic [3:0]  dly = 0, irq;
    int          n_mismatch = 0, checked = 0, n_acc = 0, n_irq = 0, cyc = 0, e;
    logic [1:0]  order[$];
    // Source bit expected per selector code, 16 for none
    int row_src[32] = '{16,16,15,0,1,2,3,4,16,16,16,16,13,16,5,6,7,8,16,16,16,16,16,9,10,11,12,16,16,16,16,14};
    aptc_top i_dut (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(rdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_SPECIAL_TRIG(src[0]), .I_PWM_PRI_TRIG(src[4:1]),
        .I_PWM_SEC_TRIG(src[8:5]), .I_PWM_CL_TRIG(src[12:9]), .I_TMR1_MATCH(src[13]), .I_TMR2_MATCH(src[14]),
        .I_GLOBAL_SW_TRIG(src[15]), .O_CONV_REQ(req), .O_CONV_PAIR(pair), .I_CONV_ACK(ack),
        .I_CONV_DONE(done), .O_PAIR_IRQ(irq));
    aptc_seq_model i_seq (.i_clk(clk), .i_arst_n(rst_n), .i_req(req), .i_delay(dly), .o_ack(ack), .o_done(done));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        checked++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = rdata;
    endtask
    task automatic pulse(input logic [15:0] m);
        src <= m;
        repeat (2) @(posedge clk);
        src <= 16'h0;
        repeat (40) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (req === 1'b1 && ack === 1'b1)
        begin
            n_acc <= n_acc + 1;
            order.push_back(pair);
        end
        if (rst_n === 1'b1 && irq !== 4'h0)
            n_irq <= n_irq + 1;
        if (cyc > 10000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        dly <= 4'h3;
        for (int i = 0; i < 3; i++)
        begin
            bus(0, (i == 2) ? 32'h10 : 32'(i * 4), 0, rd);
            chk("reset_or_unmapped", {16'h0, CTRL_RESET}, rd);
        end
        for (int c = 0; c < 32; c++)
        begin
            e = n_acc + 32'(row_src[c] < 16);
            bus(1, ADDR_CTRL_ONE, {24'h0, 3'b100, 5'(c)}, rd);
            pulse(~(16'h1 << row_src[c]));
            chk("stray", e - 32'(row_src[c] < 16), n_acc);
            pulse(16'h1 << row_src[c]);
            chk("fire", e, n_acc);
            chk("irq", e, n_irq);
            bus(0, ADDR_CTRL_ONE, 0, rd);
            chk("ctrl_one", {24'h0, 3'b100, 5'(c)}, rd);
        end
        dly <= 4'hf;
        e = n_acc;
        bus(1, ADDR_CTRL_TWO, 32'h21, rd);
        repeat (6) @(posedge clk);
        bus(0, ADDR_CTRL_TWO, 0, rd);
        chk("sw_pend", 32'h41, rd);
        repeat (40) @(posedge clk);
        bus(0, ADDR_CTRL_TWO, 0, rd);
        chk("sw_done", 32'h01, rd);
        chk("sw_pair", 2, order[$]);
        chk("sw_noirq", e, n_irq);
        bus(1, ADDR_CTRL_TWO, 32'h2300, rd);
        repeat (10) @(posedge clk);
        bus(0, ADDR_CTRL_TWO, 0, rd);
        chk("sw_refused", 32'h0300, rd);
        chk("sw_refused_acc", e + 1, n_acc);
        bus(1, ADDR_CTRL_ONE, 32'h8282, rd);
        bus(1, ADDR_CTRL_TWO, 32'h8282, rd);
        order.delete();
        e = n_irq + 4;
        src <= 16'h8000;
        repeat (6) @(posedge clk);
        src <= 16'h0;
        repeat (2) @(posedge clk);
        bus(0, ADDR_STATUS, 0, rd);
        chk("status_busy", 32'h9, rd);
        pulse(16'h8000);
        repeat (160) @(posedge clk);
        bus(0, ADDR_STATUS, 0, rd);
        chk("status_idle", 32'h6, rd);
        chk("served", 4, order.size());
        foreach (order[i])
            chk("order", i, order[i]);
        chk("irq_all", e, n_irq);
        final_report();
    end
endmodule // aptc_top_tb
`default_nettype wire
